// ===== src/pio_map.vh
// Register map, field positions, reset values and pin layout of the programmable I/O ports.
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// ----------------------------------------------------------------
// Pin layout
// ----------------------------------------------------------------
`define PIO_NPORT           11
`define PIO_NPIN            88
`define PIO_NGRP            22
`define PIO_GRP_SIZE        4
`define PIO_IN_ONLY_PIN     85
`define PIO_SHARED_PORT     1
`define PIO_BUS_GRP_MASK    22'h000dff
`define PIO_DIR_IMPL_MASK   88'hdf_ffff_ffff_ffff_ffff_ffff
`define PIO_PORT_SPAN       8'h2c

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define PIO_OFS_DATA        8'h00
`define PIO_OFS_DIR         8'h40
`define PIO_OFS_PULL        8'h80
`define PIO_OFS_CTRL        8'h84
`define PIO_OFS_MODE        8'h88

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PIO_CTRL_LATCH_RD   0
`define PIO_MODE_SINGLE     2'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIO_RST_DIR         88'h00
`define PIO_RST_LATCH       88'h00
`define PIO_RST_PULL        22'h000000
`define PIO_RST_CTRL        1'h0

`endif

// ===== src/pio_pin.v
// One port pin cell: output latch steering, output enable and pull-up request.
`timescale 1ns/10ps

module pio_pin #(
	parameter INPUT_ONLY = 0
) (
	// Clock and reset.
	input  wire mclk,
	input  wire rst_n,
	// Controls from the register file.
	input  wire dir_out,
	input  wire latch,
	input  wire pull_grp,
	// Peripheral takeover.
	input  wire periph_oe,
	input  wire periph_out,
	// Pin side.
	output reg  pin_out,
	output reg  pin_oe_n,
	output reg  pin_pullup
);

	wire drive;

	assign drive = periph_oe | dir_out;

	always @(posedge mclk) begin
		if (!rst_n) begin
			pin_out    <= 1'b0;
			pin_oe_n   <= 1'b1;
			pin_pullup <= 1'b0;
		end else if (INPUT_ONLY != 0) begin
			// This pin never drives and never pulls up.
			pin_out    <= 1'b0;
			pin_oe_n   <= 1'b1;
			pin_pullup <= 1'b0;
		end else begin
			pin_out    <= periph_oe ? periph_out : latch;
			pin_oe_n   <= ~drive;
			pin_pullup <= pull_grp & ~drive;
		end
	end

endmodule

// ===== src/pio_ports.v
// Programmable I/O port block with an Avalon-MM register slave.
`timescale 1ns/10ps
`include "pio_map.vh"

module pio_ports (
	// Clock and reset.
	input  wire          mclk,
	input  wire          rst_n,
	// Avalon-MM slave.
	input  wire [7:0]    address,
	input  wire          read,
	input  wire          write,
	input  wire [3:0]    byteenable,
	input  wire [31:0]   writedata,
	output reg  [31:0]   readdata,
	output reg           waitrequest,
	// Processor mode and external bus setup.
	input  wire [1:0]    proc_mode,
	input  wire          ext_bus_8bit,
	input  wire          shared_port_mux,
	// Peripheral output takeover, one bit per pin.
	input  wire [87:0]   periph_oe,
	input  wire [87:0]   periph_out,
	// Port pins.
	input  wire [87:0]   pin_in,
	output wire [87:0]   pin_out,
	output wire [87:0]   pin_oe_n,
	output wire [87:0]   pin_pullup
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	wire [87:0] latch;
	wire [87:0] dir;
	reg  [21:0] pull;
	reg         ctrl_latch_rd;

	wire        ext_mode;
	wire        ctrl_valid;
	wire [21:0] pull_eff;
	wire [87:0] read_view;
	wire [7:0]  shared_view;
	wire        req;
	wire        take;
	wire        wr_take;
	wire [7:0]  data_rel;
	wire [7:0]  dir_rel;
	wire [5:0]  data_word;
	wire [5:0]  dir_word;
	wire        hit_data;
	wire        hit_dir;
	reg  [31:0] next_readdata;

	localparam [87:0] RST_LATCH = `PIO_RST_LATCH;
	localparam [87:0] RST_DIR   = `PIO_RST_DIR;
	localparam [87:0] DIR_IMPL  = `PIO_DIR_IMPL_MASK;

	assign ext_mode   = (proc_mode != `PIO_MODE_SINGLE);
	assign ctrl_valid = ext_mode & ext_bus_8bit & shared_port_mux;

	// Pull-ups of the bus pin group fall away once the external bus owns them.
	assign pull_eff = pull & ~({22{ext_mode}} & `PIO_BUS_GRP_MASK);

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `PIO_NPIN; g = g + 1) begin : g_pin
			pio_pin #(
				.INPUT_ONLY (g == `PIO_IN_ONLY_PIN)
			) u_pin (
				.mclk       (mclk),
				.rst_n      (rst_n),
				.dir_out    (dir[g]),
				.latch      (latch[g]),
				.pull_grp   (pull_eff[g / `PIO_GRP_SIZE]),
				.periph_oe  (periph_oe[g]),
				.periph_out (periph_out[g]),
				.pin_out    (pin_out[g]),
				.pin_oe_n   (pin_oe_n[g]),
				.pin_pullup (pin_pullup[g])
			);
			// Inputs show the pin, outputs show the latch.
			assign read_view[g] = dir[g] ? latch[g] : pin_in[g];
		end
	endgenerate

	// The shared port may be forced to read back its latch.
	assign shared_view = (ctrl_valid & ctrl_latch_rd) ? latch[15:8] : read_view[15:8];

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Waitrequest rests high; each request is answered one cycle after it
	// appears, and a write lands only on the edge where waitrequest is low.
	assign req  = read | write;
	assign take    = req & ~waitrequest;
	assign wr_take = take & write;

	assign data_rel  = address - `PIO_OFS_DATA;
	assign dir_rel   = address - `PIO_OFS_DIR;
	assign data_word = data_rel[7:2];
	assign dir_word  = dir_rel[7:2];
	assign hit_data  = (address >= `PIO_OFS_DATA) && (address < `PIO_OFS_DATA + `PIO_PORT_SPAN);
	assign hit_dir   = (address >= `PIO_OFS_DIR) && (address < `PIO_OFS_DIR + `PIO_PORT_SPAN);

	always @(posedge mclk) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h00000000;
		end else begin
			waitrequest <= ~(req & waitrequest);
			if (read & waitrequest) begin
				readdata <= next_readdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	always @* begin
		next_readdata = 32'h00000000;
		if (hit_data) begin
			if (data_word == `PIO_SHARED_PORT) begin
				next_readdata[7:0] = shared_view;
			end else begin
				next_readdata[7:0] = read_view[data_word * 8 +: 8];
			end
		end else if (hit_dir) begin
			next_readdata[7:0] = dir[dir_word * 8 +: 8];
		end else if (address == `PIO_OFS_PULL) begin
			next_readdata[21:0] = pull;
		end else if (address == `PIO_OFS_CTRL) begin
			next_readdata[`PIO_CTRL_LATCH_RD] = ctrl_latch_rd;
		end else if (address == `PIO_OFS_MODE) begin
			next_readdata[2:0] = {ctrl_valid, proc_mode};
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Each port owns one latch byte and one direction byte, written through
	// byte lane 0 on the edge where the request is taken.
	genvar p;
	generate
		for (p = 0; p < `PIO_NPORT; p = p + 1) begin : g_port
			reg  [7:0] latch_byte;
			reg  [7:0] dir_byte;
			wire       wr_latch;
			wire       wr_dir;

			assign wr_latch = wr_take & hit_data & ({26'h0, data_word} == p) & byteenable[0];
			assign wr_dir   = wr_take & hit_dir & ({26'h0, dir_word} == p) & byteenable[0];

			always @(posedge mclk) begin
				if (!rst_n) begin
					latch_byte <= RST_LATCH[p * 8 +: 8];
					dir_byte   <= RST_DIR[p * 8 +: 8];
				end else begin
					if (wr_latch) begin
						latch_byte <= writedata[7:0];
					end
					if (wr_dir) begin
						// The input-only position stays zero whatever is written.
						dir_byte <= writedata[7:0] & DIR_IMPL[p * 8 +: 8];
					end
				end
			end

			assign latch[p * 8 +: 8] = latch_byte;
			assign dir[p * 8 +: 8]   = dir_byte;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pull-up and port control registers
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			pull          <= `PIO_RST_PULL;
			ctrl_latch_rd <= `PIO_RST_CTRL;
		end else if (wr_take) begin
			if (address == `PIO_OFS_PULL) begin
				if (byteenable[0]) begin
					pull[7:0] <= writedata[7:0];
				end
				if (byteenable[1]) begin
					pull[15:8] <= writedata[15:8];
				end
				if (byteenable[2]) begin
					pull[21:16] <= writedata[21:16];
				end
			end
			if (address == `PIO_OFS_CTRL && byteenable[0]) begin
				ctrl_latch_rd <= writedata[`PIO_CTRL_LATCH_RD];
			end
		end
	end

endmodule

// ===== test/pio_ext_dev.sv
// External devices and wiring seen by the port pins.
`timescale 1ns/10ps

module pio_ext_dev (
	input  wire        mclk,
	input  wire [87:0] pin_out,
	input  wire [87:0] pin_oe_n,
	input  wire [87:0] pin_pullup,
	input  wire [87:0] ext_en,
	input  wire [87:0] ext_val,
	output wire [87:0] pin_in
);
	reg [87:0] drift = 88'h0;

	// A line nobody drives or pulls wanders every cycle, so it never reads as a stable level.
	always @(posedge mclk) begin
		drift <= ~drift;
	end

	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pin_pullup | drift));
endmodule

// ===== test/pio_ports_chk.sv
// Concurrent checks on the bus handshake and the port pins.
`timescale 1ns/10ps
`include "pio_map.vh"

module pio_ports_chk (
	input wire        mclk,
	input wire        rst_n,
	input wire        read,
	input wire        write,
	input wire        waitrequest,
	input wire [1:0]  proc_mode,
	input wire [87:0] periph_oe,
	input wire [87:0] periph_out,
	input wire [87:0] pin_out,
	input wire [87:0] pin_oe_n,
	input wire [87:0] pin_pullup
);
	localparam [87:0] BUS_PINS = 88'hff0f_ffff_ffff;
	localparam [87:0] IO_PINS  = `PIO_DIR_IMPL_MASK;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_req; (read || write) && waitrequest; endsequence
	sequence s_ans; !waitrequest ##1 waitrequest; endsequence

	property p_ans; s_req |=> s_ans; endproperty
	property p_noans; $fell(waitrequest) |-> $past(read || write); endproperty
	property p_per_oe; (periph_oe & IO_PINS) != 88'h0 |=> (pin_oe_n & $past(periph_oe) & IO_PINS) == 88'h0; endproperty
	property p_per_out; (periph_oe & IO_PINS) != 88'h0 |=> ((pin_out ^ $past(periph_out)) & $past(periph_oe) & IO_PINS) == 88'h0; endproperty
	property p_pull_drv; (pin_pullup & ~pin_oe_n) == 88'h0; endproperty
	property p_pull_mode; proc_mode != 2'h0 |=> (pin_pullup & BUS_PINS) == 88'h0; endproperty
	property p_in_only; pin_oe_n[`PIO_IN_ONLY_PIN] && !pin_pullup[`PIO_IN_ONLY_PIN]; endproperty
	property p_rst; disable iff (1'b0) !rst_n |=> &pin_oe_n && pin_pullup == 88'h0 && waitrequest; endproperty

	a_ans: assert property (p_ans) else $error("request not answered after one wait cycle");
	a_noans: assert property (p_noans) else $error("answer without a request");
	a_per_oe: assert property (p_per_oe) else $error("peripheral output pin not driven");
	a_per_out: assert property (p_per_out) else $error("peripheral value not on pin");
	a_pull_drv: assert property (p_pull_drv) else $error("pull-up on a driven pin");
	a_pull_mode: assert property (p_pull_mode) else $error("bus pin pull-up in expansion mode");
	a_in_only: assert property (p_in_only) else $error("input-only pin driven or pulled");
	a_rst: assert property (p_rst) else $error("pins not released in reset");
endmodule

// ===== test/test_pio_ports.sv
// Self-checking bench for the programmable I/O ports.
`timescale 1ns/10ps
`include "pio_map.vh"

module test_pio_ports;
	reg         mclk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [7:0]  address = 8'h00;
	reg         read = 1'b0;
	reg         write = 1'b0;
	reg  [31:0] writedata = 32'h0;
	reg  [1:0]  proc_mode = 2'h0;
	reg         ext_bus_8bit = 1'b0;
	reg         shared_port_mux = 1'b0;
	reg  [87:0] periph_oe = 88'h0;
	reg  [87:0] periph_out = 88'h0;
	reg  [87:0] ext_en = 88'h0;
	reg  [87:0] ext_val = 88'h0;
	reg  [87:0] dir = 88'h0;
	reg  [87:0] lat = 88'h0;
	reg  [31:0] rd;
	reg  [31:0] r;
	wire [31:0] readdata;
	wire        waitrequest;
	wire [87:0] pin_in, pin_out, pin_oe_n, pin_pullup;
	integer     seed = 32'h652f;
	integer     miscompares = 0;
	integer     n_checks = 0;
	integer     i;

	pio_ports DUT (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(4'hf), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.proc_mode(proc_mode), .ext_bus_8bit(ext_bus_8bit), .shared_port_mux(shared_port_mux),
		.periph_oe(periph_oe), .periph_out(periph_out), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup));
	pio_ext_dev u_ext (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	initial forever #10 mclk = ~mclk;
	initial begin
		#200000;
		miscompares = miscompares + 1;
		end_of_test;
	end

	task check(input [87:0] seen, input [87:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		@(posedge mclk);
		while (waitrequest !== 1'b0) @(posedge mclk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask
	function [87:0] exp_data(input integer p);
		reg [87:0] v;
		v = (dir & lat) | (~dir & ext_val);
		exp_data = {80'h0, v[8 * p +: 8]};
	endfunction
	function [87:0] grp(input [21:0] g);
		for (int k = 0; k < 88; k = k + 1) grp[k] = g[k / 4];
	endfunction
	task end_of_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		bus(0, 8'h40, 0);
		check(rd, 0);
		bus(0, 8'h84, 0);
		check(rd, 0);
		ext_en <= {88{1'b1}};
		for (i = 0; i < 11; i = i + 1) begin
			r = $random(seed);
			if (i == 10) r[7:0] = 8'hff;
			dir[8 * i +: 8] = r[7:0] & (i == 10 ? 8'hdf : 8'hff);
			lat[8 * i +: 8] = r[15:8];
			ext_val[8 * i +: 8] <= r[23:16];
			bus(1, 8'(8'h40 + 4 * i), {24'h0, r[7:0]});
			bus(1, 8'(4 * i), {24'h0, r[15:8]});
			bus(0, 8'(8'h40 + 4 * i), 0);
			check(rd, dir[8 * i +: 8]);
			bus(0, 8'(4 * i), 0);
			check(rd, exp_data(i));
		end
		check(pin_oe_n, ~dir);
		check(pin_out & dir, lat & dir);
		bus(1, 8'h90, 32'hffffffff);
		bus(0, 8'h90, 0);
		check(rd, 0);
		ext_en <= 88'h0;
		r = $random(seed);
		bus(1, 8'h80, {10'h0, r[21:0]});
		@(posedge mclk);
		check(pin_pullup, ~dir & `PIO_DIR_IMPL_MASK & grp(r[21:0]));
		proc_mode <= 2'h1;
		repeat (2) @(posedge mclk);
		check(pin_pullup, ~dir & `PIO_DIR_IMPL_MASK & grp(r[21:0] & ~`PIO_BUS_GRP_MASK));
		dir[15:8] = 8'h0f;
		lat[15:8] = 8'ha5;
		ext_en <= {88{1'b1}};
		ext_val[15:8] <= 8'h3c;
		shared_port_mux <= 1'b1;
		bus(1, 8'h44, 32'h0f);
		bus(1, 8'h04, 32'ha5);
		for (i = 0; i < 3; i = i + 1) begin
			ext_bus_8bit <= (i != 1);
			bus(1, 8'h84, {31'h0, i < 2});
			bus(0, 8'h04, 0);
			check(rd, i == 0 ? {80'h0, lat[15:8]} : exp_data(1));
			bus(0, 8'h88, 0);
			check(rd, {85'h0, i != 1, proc_mode});
		end
		// Software keeps peripheral input and analog pins at input; only outputs are taken over.
		r = $random(seed);
		periph_oe <= {r[23:0], r, ~r} & `PIO_DIR_IMPL_MASK;
		periph_out <= {r, ~r[23:0], r};
		repeat (2) @(posedge mclk);
		check(pin_oe_n, ~(dir | periph_oe));
		check(pin_out & periph_oe, periph_out & periph_oe);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		check(pin_oe_n, {88{1'b1}});
		bus(0, 8'h80, 0);
		check(rd, 0);
		end_of_test;
	end
endmodule

bind pio_ports pio_ports_chk u_chk (.mclk(mclk), .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
	.proc_mode(proc_mode), .periph_oe(periph_oe), .periph_out(periph_out), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup));
